// ===== bench/ubcg_line_model.sv
// Remote serial transmitter driving the receive line
module ubcg_line_model
(
  // Bench clock
  input  wire logic i_clk,
  // Serial line, idles high
  output logic      o_rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
    o_rxd = 1'b1;
  // One frame at exactly the receiver's bit length
  task automatic send(input logic [7:0] d, input int bc);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      o_rxd <= f[i];
      repeat (bc) @(posedge i_clk);
    end
  endtask : send
  task automatic low(input int n);
    o_rxd <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_rxd <= 1'b1;
  endtask : low
endmodule : ubcg_line_model

// ===== bench/ubcg_monitor.sv
// Checker of baud clock generator port timing
module ubcg_monitor
  import ubcg_pkg::*;
(
  // Requests and timer
  input wire logic        i_core_clk,
  input wire logic        i_rst_b,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        i_timer_ch2_irq,
  input wire logic        i_rxd,
  // Outputs watched
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_op_clk_en,
  input wire logic        o_half_bit_en,
  input wire logic        o_rx_sample
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0]  div_q;
  logic [7:0]  pre_q;
  logic        sel_q, en_q;
  logic [1:0]  quiet, ha, oa;
  logic [7:0]  hc;
  logic [11:0] gap;
  logic        wr;
  logic [3:0]  code;
  assign wr   = i_psel & i_penable & o_pready & i_pwrite;
  assign code = sel_q ? pre_q[7:4] : pre_q[3:0];
  // Shadow of the setup and settle counters after each write
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      {div_q, pre_q, sel_q, en_q, quiet, ha, oa, hc, gap} <= '0;
    else
    begin
      if (wr && i_paddr == DATA_ADDR)
        div_q <= i_pwdata[15:9];
      if (wr && i_paddr == PRESCALER_ADDR)
        pre_q <= i_pwdata[7:0];
      if (wr && i_paddr == MODE_ADDR)
      begin
        sel_q <= i_pwdata[CLK_SEL_BIT];
        en_q  <= i_pwdata[ENABLE_BIT];
      end
      quiet <= wr ? 2'h0 : quiet + 2'(quiet != 2'h3);
      ha    <= (wr || $changed(i_rxd)) ? 2'h0 : ha + 2'(o_half_bit_en && ha != 2'h3);
      oa    <= wr ? 2'h0 : oa + 2'(o_op_clk_en && oa != 2'h3);
      hc    <= o_half_bit_en ? 8'h0 : hc + 8'(o_op_clk_en);
      gap   <= o_op_clk_en ? 12'h1 : gap + 12'h1;
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  chk_pready_wait:
    assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("pready not one cycle after access");
  chk_slverr_ready:
    assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  chk_half_count:
    assert property (o_half_bit_en && ha == 2'h3 |-> hc + 8'(o_op_clk_en) == 8'(div_q) + 8'h1)
    else $error("half bit spacing wrong");
  chk_half_gap:
    assert property (o_half_bit_en && quiet == 2'h3 && div_q > 7'h1 |=> !o_half_bit_en [*2])
    else $error("half bit pulses too close");
  chk_op_period:
    assert property (o_op_clk_en && oa == 2'h3 && code < 4'hc |-> gap == (12'h1 << code))
    else $error("operation clock period wrong");
  chk_op_none:
    assert property (quiet == 2'h3 && (!en_q || code inside {[4'hc:4'he]}) |-> !o_op_clk_en)
    else $error("prohibited code makes a clock");
  chk_timer_clk:
    assert property (quiet == 2'h3 && en_q && code == PRS_TIMER
                     |=> o_op_clk_en == $past(i_timer_ch2_irq))
    else $error("timer pulse not followed");
  chk_sample_gap:
    assert property (o_rx_sample && div_q > 7'h1 |=> !o_rx_sample [*5])
    else $error("receive samples too close");
endmodule : ubcg_monitor

bind ubcg_top ubcg_monitor u_mon (.i_core_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pwdata, .i_timer_ch2_irq, .i_rxd, .o_pready, .o_pslverr, .o_op_clk_en,
  .o_half_bit_en, .o_rx_sample);

// ===== bench/ubcg_top_tb.sv
// Self-checking bench of the baud clock generator
module ubcg_top_tb
  import ubcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_core_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic        i_timer_ch2_irq = 1'b0;
  logic        i_timer_ch3_irq = 1'b0;
  logic        i_rxd;
  logic [31:0] o_prdata;
  logic        o_pready, o_pslverr, o_op_clk_en, o_half_bit_en, o_rx_sample, o_rx_bit;
  logic [32:0] rd_q[$];
  logic        bit_q[$];
  logic [31:0] seed = 32'h0000_7769;
  logic [31:0] r;
  logic [3:0]  tmr = 4'h0;
  logic [3:0]  codes[6] = '{4'h0, 4'h1, 4'h3, 4'h5, 4'hf, 4'hc};
  int          gaps[6] = '{1, 2, 8, 32, 7, 0};
  int          errors = 0;
  int          cmp_count = 0;

  ubcg_top uut (.*);
  ubcg_line_model line (.i_clk(i_core_clk), .o_rxd(i_rxd));

  initial
  begin
    forever #25 i_core_clk = ~i_core_clk;
  end

  // Timer pulses: channel 2 steady, channel 3 uneven
  always @(posedge i_core_clk)
  begin
    tmr <= (tmr == 4'h6) ? 4'h0 : tmr + 4'h1;
    i_timer_ch2_irq <= (tmr == 4'h6);
    i_timer_ch3_irq <= (tmr[1:0] == 2'h0);
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input logic [32:0] act, input logic [32:0] exp);
    cmp_count++;
    if (act !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  // One transfer; e is the expected {pslverr, read data}
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                     input logic [32:0] e);
    int n;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {16'h0000, d};
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    rd_q.push_back(e);
    n = 0;
    do
    begin
      @(posedge i_core_clk);
      n++;
    end
    while (o_pready !== 1'b1 && n < 50);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_core_clk);
    errors += int'(n >= 50);
    if (n >= 50)
      tally_and_finish();
  endtask : apb

  task automatic cfg(input logic [3:0] c, input logic s, input logic [6:0] dv);
    logic [7:0] p;
    p = s ? {c, 4'h4} : {4'h4, c};
    apb(1'b1, MODE_ADDR, 16'h0000, 33'h0);
    apb(1'b1, PRESCALER_ADDR, {8'h00, p}, 33'h0);
    apb(1'b1, MODE_ADDR, {s, 10'h000, 4'ha, 1'b1}, 33'h0);
    apb(1'b1, DATA_ADDR, {dv, 9'h000}, 33'h0);
  endtask : cfg

  // Spacing of the third pulse after setup; 0 when none comes
  task automatic measure(input logic h, input int exp);
    int g;
    repeat (3)
    begin
      g = 0;
      do
      begin
        @(posedge i_core_clk);
        g++;
      end
      while ((h ? o_half_bit_en : o_op_clk_en) !== 1'b1 && g < 400);
    end
    check(33'(g % 400), 33'(exp));
  endtask : measure

  always @(posedge i_core_clk)
  begin
    if (o_pready === 1'b1)
      check({o_pslverr, i_pwrite ? 32'h0 : o_prdata}, rd_q.size() ? rd_q.pop_front() : 33'h0);
    if (o_rx_sample === 1'b1)
      check({32'h0, o_rx_bit}, {32'h0, bit_q.size() ? bit_q.pop_front() : 1'bx});
  end

  initial
  begin
    repeat (10) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    @(posedge i_core_clk);
    apb(1'b0, PRESCALER_ADDR, 16'h0, {17'h0, PRESCALER_RST});
    apb(1'b0, MODE_ADDR, 16'h0, {17'h0, MODE_RST});
    apb(1'b0, DATA_ADDR, 16'h0, {17'h0, DATA_RST});
    apb(1'b1, 12'h010, 16'hffff, {1'b1, 32'h0});
    apb(1'b0, 12'h010, 16'h0, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++)
    begin
      r = xs() | 32'h2;
      apb(1'b1, DATA_ADDR, {r[6:0], 9'h000}, 33'h0);
      apb(1'b0, DATA_ADDR, 16'h0, {17'h0, r[6:0], 9'h000});
    end
    foreach (codes[i])
    begin
      cfg(codes[i], i[0], 7'h2);
      measure(1'b0, gaps[i]);
    end
    cfg(4'h1, 1'b1, 7'h5);
    measure(1'b1, 12);
    cfg(4'h0, 1'b0, 7'h7f);
    measure(1'b1, 128);
    cfg(4'h0, 1'b0, 7'h4);
    repeat (2)
    begin
      r = xs();
      for (int j = 0; j < 8; j++)
        bit_q.push_back(r[j]);
      bit_q.push_back(1'b1);
      line.send(r[7:0], 10);
    end
    for (int k = 0; k < 300 && bit_q.size() > 0; k++)
      @(posedge i_core_clk);
    errors += bit_q.size();
    apb(1'b0, STATUS_ADDR, 16'h0, {26'h0, 3'b010, 4'h9});
    line.low(2);
    repeat (100) @(posedge i_core_clk);
    apb(1'b0, STATUS_ADDR, 16'h0, {26'h0, 3'b010, 4'h0});
    tally_and_finish();
  end
endmodule : ubcg_top_tb

// ===== pkg/ubcg_pkg.sv
// Package: register map, field layout and constants of the baud clock generator
package ubcg_pkg;

  // Register byte addresses
  localparam logic [11:0] PRESCALER_ADDR   = 12'h000;
  localparam logic [11:0] MODE_ADDR        = 12'h004;
  localparam logic [11:0] DATA_ADDR        = 12'h008;
  localparam logic [11:0] STATUS_ADDR      = 12'h00c;

  // Field positions
  localparam int          LOW_PRS_LSB      = 0;
  localparam int          HIGH_PRS_LSB     = 4;
  localparam int          CLK_SEL_BIT      = 15;
  localparam int          ENABLE_BIT       = 0;
  localparam int          DIV_LSB          = 9;
  localparam int          DIV_W            = 7;

  // Reset values
  localparam logic [15:0] PRESCALER_RST    = 16'h0000;
  localparam logic [15:0] MODE_RST         = 16'h0000;
  localparam logic [15:0] DATA_RST         = 16'h0000;

  // Prescaler codes
  localparam logic [3:0]  PRS_MAX_DIV      = 4'hb;
  localparam logic [3:0]  PRS_TIMER        = 4'hf;

  // Unit number selects which timer interrupt clocks the unit
  localparam logic        UNIT_NUMBER      = 1'b0;

  // Bit counter width: start, up to 9 data bits, parity, 2 stop
  localparam int          BITCNT_W         = 4;

  typedef struct packed {
    logic       enable;
    logic       clk_sel;
    logic [3:0] low_prs;
    logic [3:0] high_prs;
    logic [6:0] divider;
    logic [3:0] frame_bits;
  } ubcg_cfg_t;

  typedef struct packed {
    logic                rx_busy;
    logic                frame_ok;
    logic                frame_err;
    logic [BITCNT_W-1:0] bit_index;
  } ubcg_stat_t;

endpackage : ubcg_pkg

// ===== src/ubcg_top.sv
// Module: baud clock generator with receive sampling, reached over APB
// What this block does
// - The bit rate is the operation clock divided by divider plus one, then by 2.
// - The clock select bit picks the low prescaler field at 0 and the high one at 1.
// - Prescaler codes 0 to 11 divide the system clock by 2 to that power; 15 picks a timer.
// - Code 15 clocks unit 0 from timer channel 2 and unit 1 from timer channel 3.
// - Receive tolerance follows from k as divider plus one and the frame length.
// - After a start bit each bit is latched at instants set by the divider.
module ubcg_top
  import ubcg_pkg::*;
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Timer interrupt pulses
  input  wire logic        i_timer_ch2_irq,
  input  wire logic        i_timer_ch3_irq,
  // Serial line
  input  wire logic        i_rxd,
  // Channel timing outputs
  output logic             o_op_clk_en,
  output logic             o_half_bit_en,
  output logic             o_rx_sample,
  output logic             o_rx_bit
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ubcg_rx_t;

  logic [15:0] prescaler, next_prescaler;
  logic [15:0] mode,      next_mode;
  logic [15:0] data,      next_data;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr;
  ubcg_cfg_t   cfg;
  ubcg_stat_t  stat;
  ubcg_rx_t    rx_state, next_rx_state;

  // APB registers
  wire access = i_psel && i_penable && !o_pready;
  wire known  = (i_paddr == PRESCALER_ADDR) || (i_paddr == MODE_ADDR) ||
                (i_paddr == DATA_ADDR) || (i_paddr == STATUS_ADDR);

  always_comb
  begin
    next_prescaler = prescaler;
    next_mode      = mode;
    next_data      = data;
    next_prdata    = o_prdata;
    next_pready    = access;
    next_pslverr   = access && !known;
    if (access && i_pwrite)
    begin
      unique case (i_paddr)
        PRESCALER_ADDR: next_prescaler = i_pwdata[15:0];
        MODE_ADDR:      next_mode      = i_pwdata[15:0];
        DATA_ADDR:      next_data      = i_pwdata[15:0];
        default:        next_data      = data;
      endcase
    end
    if (access && !i_pwrite)
    begin
      unique case (i_paddr)
        PRESCALER_ADDR: next_prdata = {16'h0000, prescaler};
        MODE_ADDR:      next_prdata = {16'h0000, mode};
        DATA_ADDR:      next_prdata = {16'h0000, data};
        STATUS_ADDR:    next_prdata = {{25{1'b0}}, stat};
        default:        next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      prescaler <= PRESCALER_RST;
      mode      <= MODE_RST;
      data      <= DATA_RST;
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      prescaler <= next_prescaler;
      mode      <= next_mode;
      data      <= next_data;
      o_prdata  <= next_prdata;
      o_pready  <= next_pready;
      o_pslverr <= next_pslverr;
    end
  end

  always_comb
  begin
    cfg.enable     = mode[ENABLE_BIT];
    cfg.clk_sel    = mode[CLK_SEL_BIT];
    cfg.low_prs    = prescaler[LOW_PRS_LSB +: 4];
    cfg.high_prs   = prescaler[HIGH_PRS_LSB +: 4];
    cfg.divider    = data[DIV_LSB +: DIV_W];
    cfg.frame_bits = mode[4:1];
  end

  // Rx synchroniser: three stages, change taken when stages two and three agree
  logic [2:0] rx_sync;
  logic       rx_level, next_rx_level;

  always_comb
  begin
    next_rx_level = (rx_sync[1] == rx_sync[2]) ? rx_sync[2] : rx_level;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_sync  <= 3'h7;
      rx_level <= 1'b1;
    end
    else
    begin
      rx_sync  <= {rx_sync[1:0], i_rxd};
      rx_level <= next_rx_level;
    end
  end

  // Prescaler: free counter, enable pulse on divided rate or timer pulse
  logic [10:0] pre_cnt, next_pre_cnt;
  logic        op_en, next_op_en;
  logic [3:0]  sel_code;
  logic [10:0] pre_mask;

  always_comb
  begin
    sel_code     = cfg.clk_sel ? cfg.high_prs : cfg.low_prs;
    pre_mask     = 11'h7ff >> (4'(PRS_MAX_DIV) - sel_code);
    next_pre_cnt = pre_cnt + 11'h001;
    if (sel_code == PRS_TIMER)
      next_op_en = (UNIT_NUMBER == 1'b0) ? i_timer_ch2_irq : i_timer_ch3_irq;
    else if (sel_code == 4'h0)
      next_op_en = 1'b1;
    else if (sel_code <= PRS_MAX_DIV)
      next_op_en = ((pre_cnt & pre_mask) == pre_mask);
    else
      next_op_en = 1'b0;
    next_op_en = next_op_en && cfg.enable;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pre_cnt <= 11'h000;
      op_en   <= 1'b0;
    end
    else
    begin
      pre_cnt <= next_pre_cnt;
      op_en   <= next_op_en;
    end
  end

  // Half-bit divider: reload with divider value, one half bit per k op clocks
  logic [6:0] div_cnt, next_div_cnt;
  logic       half_en, next_half_en;

  always_comb
  begin
    next_div_cnt = div_cnt;
    next_half_en = 1'b0;
    if (!cfg.enable)
      next_div_cnt = cfg.divider;
    // Restart on start detection so bit centres line up with the start edge
    else if (rx_state == RX_IDLE && !rx_level)
      next_div_cnt = cfg.divider;
    else if (op_en)
    begin
      if (div_cnt == 7'h00)
      begin
        next_div_cnt = cfg.divider;
        next_half_en = 1'b1;
      end
      else
        next_div_cnt = div_cnt - 7'h01;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      div_cnt <= 7'h00;
      half_en <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      half_en <= next_half_en;
    end
  end

  // Receiver timing: start detect, sample at bit centres, check stop bit
  logic                phase, next_phase;
  logic [BITCNT_W-1:0] bit_idx, next_bit_idx;
  logic                sample, next_sample;
  logic                rx_bit, next_rx_bit;
  logic                ok, next_ok, err, next_err;

  always_comb
  begin
    next_rx_state = rx_state;
    next_phase    = phase;
    next_bit_idx  = bit_idx;
    next_sample   = 1'b0;
    next_rx_bit   = rx_bit;
    next_ok       = ok;
    next_err      = err;
    unique case (rx_state)
      RX_IDLE:
        if (cfg.enable && !rx_level)
        begin
          next_rx_state = RX_START;
          next_phase    = 1'b0;
          next_bit_idx  = '0;
        end
      RX_START:
        if (half_en)
        begin
          // Start bit centre after one half bit
          next_rx_state = rx_level ? RX_IDLE : RX_BITS;
          next_phase    = 1'b0;
        end
      RX_BITS:
        if (half_en)
        begin
          next_phase = !phase;
          if (phase)
          begin
            next_sample  = 1'b1;
            next_rx_bit  = rx_level;
            next_bit_idx = bit_idx + 1'b1;
            if (bit_idx + 1'b1 == cfg.frame_bits - 1'b1)
            begin
              // Stop bit latched: frame result, window set by k and frame length
              next_ok       = rx_level;
              next_err      = !rx_level;
              next_rx_state = RX_IDLE;
            end
          end
        end
    endcase
    if (!cfg.enable)
      next_rx_state = RX_IDLE;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rx_state <= RX_IDLE;
      phase    <= 1'b0;
      bit_idx  <= '0;
      sample   <= 1'b0;
      rx_bit   <= 1'b1;
      ok       <= 1'b0;
      err      <= 1'b0;
    end
    else
    begin
      rx_state <= next_rx_state;
      phase    <= next_phase;
      bit_idx  <= next_bit_idx;
      sample   <= next_sample;
      rx_bit   <= next_rx_bit;
      ok       <= next_ok;
      err      <= next_err;
    end
  end

  always_comb
  begin
    stat.rx_busy   = (rx_state != RX_IDLE);
    stat.frame_ok  = ok;
    stat.frame_err = err;
    stat.bit_index = bit_idx;
  end

  assign o_op_clk_en   = op_en;
  assign o_half_bit_en = half_en;
  assign o_rx_sample   = sample;
  assign o_rx_bit      = rx_bit;

endmodule : ubcg_top
